// ===== bench/gfsw_dpath.sv
// Purpose: model of the execution datapath facing the register file
// Assumes: one clock; outputs change just after a rising edge
// Notes:   each call drives one cycle of activity, then idles
`timescale 1ns/10ps
module gfsw_dpath
    import gfsw_pkg::*;
(
    input  wire logic         sys_clk_i, // processor clock
    output logic              wr_en_o,   // register write strobe
    output logic      [3:0]   wr_idx_o,  // first register
    output gfsw_size_e        wr_size_o, // operand size
    output logic      [127:0] wr_data_o, // datum, lsb aligned
    output logic              start_o,   // instruction begins
    output logic              end_o,     // instruction ends
    output logic      [5:0]   ev_o,      // iovf dovf unf fovf dz fdz
    output logic      [3:0]   cc_upd_o,  // flag update mask
    output logic      [3:0]   cc_val_o,  // flag values
    output logic      [2:0]   call_o     // entry, iv, dv
);
    // ****************************************
    // idle levels and one-cycle operations
    // ****************************************
    initial begin
        {wr_en_o, wr_idx_o, wr_data_o, start_o, end_o} = '0;
        {ev_o, cc_upd_o, cc_val_o, call_o} = '0;
        wr_size_o = GFSW_SZ_LONG;
    end
    // register write; spans that wrap past register 15 are never issued
    task wreg(input logic [3:0] n, input gfsw_size_e s,
              input logic [127:0] d);
        if ((s == GFSW_SZ_QUAD && n == 4'hf) ||
            (s == GFSW_SZ_OCTA && n > 4'hc)) return;
        @(posedge sys_clk_i);
        wr_en_o <= 1'b1;
        wr_idx_o <= n;
        wr_size_o <= s;
        wr_data_o <= d;
        @(posedge sys_clk_i);
        wr_en_o <= 1'b0;
    endtask
    // instruction events, flag updates and call entry for one cycle
    task op(input logic s, e, input logic [5:0] v,
            input logic [3:0] u, cv, input logic [2:0] c);
        @(posedge sys_clk_i);
        {start_o, end_o, ev_o, cc_upd_o, cc_val_o, call_o} <= {s,e,v,u,cv,c};
        @(posedge sys_clk_i);
        {start_o, end_o, ev_o, cc_upd_o, cc_val_o, call_o} <= '0;
    endtask
endmodule // gfsw_dpath

// ===== bench/tb.sv
// Purpose: self-checking bench for the register file and status word
// Assumes: bus master waits on waitrequest; datapath model drives writes, events, flags and calls; bench drives read selects
// Notes:   each scenario task drives the block and judges the outcome
`timescale 1ns/10ps
module tb;
    import gfsw_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic sys_clk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0;
    logic avs_write_i = 1'b0, avs_waitrequest_o, wr_en_i;
    logic insn_start_i, insn_end_i, trace_pending_o, trace_fault_o;
    logic int_ovf_trap_o, dec_ovf_trap_o, flt_unf_fault_o;
    logic flt_ovf_fault_o, div_zero_trap_o, flt_div_fault_o;
    logic [7:0] avs_address_i = 8'h00;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdat;
    logic [31:0] fld_data_o, program_counter_reg_o, stack_pointer_reg_o;
    logic [3:0] avs_byteenable_i = 4'hf, rd_idx_i = 4'h0, fld_idx_i = 4'h0;
    logic [3:0] wr_idx_i, cc_upd_i, cc_val_i;
    logic [4:0] fld_pos_i = 5'd28; // start bit within 0..31
    logic [5:0] fld_len_i = 6'd8, ev;
    logic [2:0] cl;
    logic [15:0] processor_status_word_o;
    logic [127:0] wr_data_i, rd_data_o;
    gfsw_size_e rd_size_i = GFSW_SZ_LONG, wr_size_i;
    int miscompares = 0, num_checks = 0;
    wire [6:0] pul = {trace_fault_o, int_ovf_trap_o, dec_ovf_trap_o,
        flt_unf_fault_o, flt_ovf_fault_o, div_zero_trap_o, flt_div_fault_o};
    always #5 sys_clk_i = ~sys_clk_i;
    gfsw_core DUT (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
        .avs_waitrequest_o, .wr_en_i, .wr_idx_i, .wr_size_i, .wr_data_i,
        .rd_idx_i, .rd_size_i, .rd_data_o, .fld_idx_i, .fld_pos_i,
        .fld_len_i, .fld_data_o, .psw_wr_i(1'b0), .psw_wdata_i(16'h0000),
        .cc_upd_i, .cc_val_i, .call_entry_i(cl[2]), .call_iv_i(cl[1]),
        .call_dv_i(cl[0]), .processor_status_word_o, .insn_start_i,
        .insn_end_i, .int_ovf_i(ev[5]), .dec_ovf_i(ev[4]),
        .flt_unf_i(ev[3]), .flt_ovf_i(ev[2]), .div_zero_i(ev[1]),
        .flt_div_zero_i(ev[0]), .trace_pending_o, .trace_fault_o,
        .int_ovf_trap_o, .dec_ovf_trap_o, .flt_unf_fault_o,
        .flt_ovf_fault_o, .div_zero_trap_o, .flt_div_fault_o,
        .program_counter_reg_o, .stack_pointer_reg_o);
    gfsw_dpath P (.sys_clk_i, .wr_en_o(wr_en_i), .wr_idx_o(wr_idx_i),
        .wr_size_o(wr_size_i), .wr_data_o(wr_data_i), .start_o(insn_start_i),
        .end_o(insn_end_i), .ev_o(ev), .cc_upd_o(cc_upd_i),
        .cc_val_o(cc_val_i), .call_o(cl));
    // ****************************************
    // shared tasks
    // ****************************************
    task chk(input logic [127:0] g, e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one bus access, held until waitrequest is sampled low at an edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [3:0] be);
        @(posedge sys_clk_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
        rdat = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task rsel(input logic [3:0] n, input gfsw_size_e s);
        @(posedge sys_clk_i);
        rd_idx_i <= n;
        rd_size_i <= s;
        fld_idx_i <= n;
        @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask
    task print_verdict();
        if (miscompares == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_bus();
        chk(processor_status_word_o, 16'h0000);
        bus(1'b1, 8'h40, 32'hdeadbeef, 4'h5);
        bus(1'b0, 8'h40, 32'h0, 4'hf);
        chk(rdat, 32'h00ad00ef);
        bus(1'b1, 8'h70, 32'h12345678, 4'hf);
        bus(1'b0, 8'h70, 32'h0, 4'hf);
        chk(rdat, 32'h12345678);
        bus(1'b0, 8'h20, 32'h0, 4'hf);
        chk(rdat, 32'h0);
    endtask
    task t_part();
        P.wreg(4'h3, GFSW_SZ_LONG, 128'ha1b2c3d4);
        P.wreg(4'h3, GFSW_SZ_BYTE, 128'h55);
        P.wreg(4'h3, GFSW_SZ_WORD, 128'h6677);
        bus(1'b0, 8'h4c, 32'h0, 4'hf);
        chk(rdat, 32'ha1b26677);
        rsel(4'h3, GFSW_SZ_BYTE);
        chk(rd_data_o, 128'h77);
        rsel(4'h3, GFSW_SZ_WORD);
        chk(rd_data_o, 128'h6677);
    endtask
    task t_multi();
        logic [63:0]  q;
        logic [127:0] o;
        q = 64'h0123456789abcdef;
        o = 128'hffeeddccbbaa99887766554433221100;
        P.wreg(4'h4, GFSW_SZ_QUAD, {64'h0, q});
        bus(1'b0, 8'h54, 32'h0, 4'hf);
        chk(rdat, q[63:32]);
        rsel(4'h4, GFSW_SZ_QUAD);
        chk(rd_data_o, {64'h0, q});
        chk(fld_data_o, (q >> 28) & 64'hff);
        P.wreg(4'hc, GFSW_SZ_OCTA, o);
        @(negedge sys_clk_i);
        chk(program_counter_reg_o, o[127:96]);
        chk(stack_pointer_reg_o, o[95:64]);
        bus(1'b0, 8'h74, 32'h0, 4'hf);
        chk(rdat, o[63:32]);
    endtask
    task t_psw();
        bus(1'b1, OFS_PSW, 32'hffff, 4'hf);
        bus(1'b0, OFS_PSW, 32'h0, 4'hf);
        chk(rdat, 32'h00ff);
        P.op(1'b0, 1'b0, 6'h0, 4'hf, 4'ha, 3'b000);
        @(negedge sys_clk_i);
        chk(processor_status_word_o, 16'h00fa);
        P.op(1'b0, 1'b0, 6'h0, 4'h4, 4'h4, 3'b000);
        @(negedge sys_clk_i);
        chk(processor_status_word_o, 16'h00fe);
        P.op(1'b0, 1'b0, 6'h0, 4'h0, 4'h0, 3'b101);
        @(negedge sys_clk_i);
        chk(processor_status_word_o, 16'h009e);
    endtask
    task t_exc();
        bus(1'b1, OFS_PSW, 32'h00f0, 4'hf);
        P.op(1'b1, 1'b1, 6'h3f, 4'h0, 4'h0, 3'b000);
        @(negedge sys_clk_i);
        chk(pul, 7'h7f);
        bus(1'b1, OFS_PSW, 32'h0000, 4'hf);
        P.op(1'b1, 1'b1, 6'h3f, 4'h0, 4'h0, 3'b000);
        @(negedge sys_clk_i);
        chk(pul, 7'h07);
        chk(processor_status_word_o[1], 1'b1);
        bus(1'b1, OFS_PSW, 32'h0010, 4'hf);
        P.op(1'b1, 1'b0, 6'h0, 4'h0, 4'h0, 3'b000);
        @(negedge sys_clk_i);
        chk(trace_pending_o, 1'b1);
        P.op(1'b0, 1'b1, 6'h0, 4'h0, 4'h0, 3'b000);
        @(negedge sys_clk_i);
        chk({trace_fault_o, trace_pending_o}, 2'b10);
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_bus();
        t_part();
        t_multi();
        t_psw();
        t_exc();
        print_verdict();
    end
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        miscompares++;
        print_verdict();
    end
endmodule // tb

// ===== include/gfsw_pkg.sv
//
// Purpose: constants and types for the general register file and status word
// Assumes: 16 x 32-bit registers, 16-bit status word, 32-bit register bus
// Notes:   bus offsets are byte addresses of aligned 32-bit words
//
package gfsw_pkg;

    // ************************************************************
    // geometry
    // ************************************************************
    localparam int          GFSW_NREG      = 16;
    localparam int          GFSW_XLEN      = 32;
    localparam int          GFSW_PSW_W     = 16;

    // ************************************************************
    // status word bit positions and reset
    // ************************************************************
    localparam int          PSW_C_BIT      = 0;
    localparam int          PSW_V_BIT      = 1;
    localparam int          PSW_Z_BIT      = 2;
    localparam int          PSW_N_BIT      = 3;
    localparam int          PSW_T_BIT      = 4;
    localparam int          PSW_IV_BIT     = 5;
    localparam int          PSW_FU_BIT     = 6;
    localparam int          PSW_DV_BIT     = 7;
    localparam logic [15:0] PSW_RST        = 16'h0000;
    localparam logic [15:0] PSW_WMASK      = 16'h00ff; // 15:8 read zero
    localparam logic [31:0] GPR_RST        = 32'h0000_0000;

    // ************************************************************
    // register bus map (byte addresses)
    // ************************************************************
    localparam logic [7:0]  OFS_PSW        = 8'h00;
    localparam logic [7:0]  OFS_STAT       = 8'h04;
    localparam logic [1:0]  OFS_GPR_PAGE   = 2'h1;   // 0x40..0x7c
    localparam int          STAT_TP_BIT    = 0;

    // ************************************************************
    // operand sizes
    // ************************************************************
    typedef enum logic [2:0] {
        GFSW_SZ_BYTE = 3'b000,
        GFSW_SZ_WORD = 3'b001,
        GFSW_SZ_LONG = 3'b010,
        GFSW_SZ_QUAD = 3'b011,
        GFSW_SZ_OCTA = 3'b100
    } gfsw_size_e;

endpackage

// ===== rtl/gfsw_core.sv
//
// Purpose: general register file, status word and exception decision
// Assumes: datapath inputs synchronous to sys_clk_i; one bus master
// Notes:   datapath writes win over bus writes in the same cycle
//
// Overview of operation
// - sixteen 32-bit registers picked by a 4-bit index, bit 0 rightmost
// - register 15 is the program counter, next instruction byte address
// - register 14 is the stack pointer, top of the stack
// - registers 13 and 12 are frame and argument pointers, still general
// - byte write changes bits 7:0, word write bits 15:0, rest kept
// - byte read returns bits 7:0, word read bits 15:0 only
// - 64-bit datum: low half in register n, high half in n+1
// - 128-bit datum in n..n+3, bits 95:64 in n+2, 127:96 in n+3
// - multi-register access wrapping from 15 to 0 is undefined
// - bit field start 0..31 over the pair n+1:n as 64 bits
// - a 16-bit status word holds condition codes and enables
// - carry set on carry out or borrow into the top bit
// - overflow set on too-large result or conversion error
// - zero set on zero result, cleared otherwise
// - negative set on negative result, cleared otherwise
// - trace enable at start sets trace pending; pending at end faults
// - integer overflow traps only when enabled; V set regardless
// - floating underflow faults only when its enable is set
// - decimal overflow traps only when enabled; V set regardless
// - divide by zero always traps, floating divide by zero faults
// - floating overflow always faults
// - call entry sets IV and DV as given, clears FU, keeps T
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps

module gfsw_core
    import gfsw_pkg::*;
(
    input  wire logic         sys_clk_i,         // 100 MHz clock
    input  wire logic         rst_i,             // async reset, high
    // register bus slave
    input  wire logic [7:0]   avs_address_i,     // byte address
    input  wire logic         avs_read_i,        // read request
    input  wire logic         avs_write_i,       // write request
    input  wire logic [31:0]  avs_writedata_i,   // write data
    input  wire logic [3:0]   avs_byteenable_i,  // write byte lanes
    output logic      [31:0]  avs_readdata_o,    // read data
    output logic              avs_waitrequest_o, // stall
    // datapath register write
    input  wire logic         wr_en_i,           // write strobe
    input  wire logic [3:0]   wr_idx_i,          // first register n
    input  wire gfsw_size_e   wr_size_i,         // operand size
    input  wire logic [127:0] wr_data_i,         // datum, lsb aligned
    // datapath register read
    input  wire logic [3:0]   rd_idx_i,          // first register n
    input  wire gfsw_size_e   rd_size_i,         // operand size
    output logic      [127:0] rd_data_o,         // datum, zero extended
    // bit field read
    input  wire logic [3:0]   fld_idx_i,         // low register n
    input  wire logic [4:0]   fld_pos_i,         // start bit 0..31
    input  wire logic [5:0]   fld_len_i,         // size 0..32
    output logic      [31:0]  fld_data_o,        // field, zero extended
    // status word
    input  wire logic         psw_wr_i,          // load whole word
    input  wire logic [15:0]  psw_wdata_i,       // word to load
    input  wire logic [3:0]   cc_upd_i,          // update mask N Z V C
    input  wire logic [3:0]   cc_val_i,          // new N Z V C
    input  wire logic         call_entry_i,      // procedure entry
    input  wire logic         call_iv_i,         // new integer enable
    input  wire logic         call_dv_i,         // new decimal enable
    output logic      [15:0]  processor_status_word_o, // live word
    // instruction boundary and exception events
    input  wire logic         insn_start_i,      // instruction begins
    input  wire logic         insn_end_i,        // instruction ends
    input  wire logic         int_ovf_i,         // integer overflow
    input  wire logic         dec_ovf_i,         // decimal overflow
    input  wire logic         flt_unf_i,         // floating underflow
    input  wire logic         flt_ovf_i,         // floating overflow
    input  wire logic         div_zero_i,        // int/dec zero divisor
    input  wire logic         flt_div_zero_i,    // float zero divisor
    output logic              trace_pending_o,   // pending trace
    output logic              trace_fault_o,     // pulse
    output logic              int_ovf_trap_o,    // pulse
    output logic              dec_ovf_trap_o,    // pulse
    output logic              flt_unf_fault_o,   // pulse
    output logic              flt_ovf_fault_o,   // pulse
    output logic              div_zero_trap_o,   // pulse
    output logic              flt_div_fault_o,   // pulse
    output logic      [31:0]  program_counter_reg_o, // register 15
    output logic      [31:0]  stack_pointer_reg_o    // register 14
);

    // ************************************************************
    // helpers
    // ************************************************************

    // registers touched by an operand of the given size
    function automatic logic [2:0] size_regs(input gfsw_size_e sz);
        unique case (sz)
            GFSW_SZ_QUAD: size_regs = 3'h2;
            GFSW_SZ_OCTA: size_regs = 3'h4;
            default:      size_regs = 3'h1;
        endcase
    endfunction

    // byte and word writes keep the untouched upper bits
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input gfsw_size_e  sz);
        unique case (sz)
            GFSW_SZ_BYTE: lane_merge = {old_v[31:8], new_v[7:0]};
            GFSW_SZ_WORD: lane_merge = {old_v[31:16], new_v[15:0]};
            default:      lane_merge = new_v;
        endcase
    endfunction

    // bus byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        for (int b = 0; b < 4; b++) begin
            be_merge[8*b +: 8] = be[b] ? new_v[8*b +: 8] : old_v[8*b +: 8];
        end
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [31:0]  gpr_r [GFSW_NREG];
    logic [31:0]  gpr_nxt [GFSW_NREG];
    logic [15:0]  psw_r;
    logic [15:0]  psw_nxt;
    logic         tp_r;
    logic         tp_nxt;
    logic         ack_r;
    logic [31:0]  rdata_r;
    logic [127:0] rd_data_r;
    logic [31:0]  fld_r;
    logic [7:0]   exc_r;
    logic [7:0]   exc_nxt;

    // ************************************************************
    // register bus decode
    // ************************************************************
    wire logic        bus_req_w  = avs_read_i | avs_write_i;
    wire logic        bus_take_w = bus_req_w & ack_r;
    wire logic        bus_wr_w   = avs_write_i & ack_r;
    wire logic        hit_psw_w  = avs_address_i[7:2] == OFS_PSW[7:2];
    wire logic        hit_stat_w = avs_address_i[7:2] == OFS_STAT[7:2];
    wire logic        hit_gpr_w  = avs_address_i[7:6] == OFS_GPR_PAGE;
    wire logic [3:0]  bus_idx_w  = avs_address_i[5:2];
    logic      [31:0] bus_rdata_w;

    // read mux, unmapped reads return zero
    assign bus_rdata_w = hit_psw_w  ? {16'h0000, psw_r} :
                         hit_stat_w ? {31'h0, tp_r} :
                         hit_gpr_w  ? gpr_r[bus_idx_w] : 32'h0000_0000;

    // one wait cycle, then the answer stands for the accepting edge
    assign avs_waitrequest_o = bus_req_w & ~ack_r;
    assign avs_readdata_o    = rdata_r;

    // ack toggles on so each request sees exactly one wait cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req_w & ~ack_r;
            if (avs_read_i & ~ack_r) begin
                rdata_r <= bus_rdata_w;
            end
        end
    end

    // ************************************************************
    // general registers
    // ************************************************************
    logic [2:0] wr_regs_w;
    assign wr_regs_w = size_regs(wr_size_i);

    // per register: datapath lane hit, else bus write, else hold
    for (genvar g = 0; g < GFSW_NREG; g++) begin : g_gpr
        logic [3:0]  lane_k;
        logic        dp_hit;
        logic        bus_hit;
        logic [31:0] lane_d;
        assign lane_k  = 4'(g) - wr_idx_i;
        assign dp_hit  = wr_en_i & (lane_k < {1'b0, wr_regs_w});
        assign lane_d  = wr_data_i[32*lane_k[1:0] +: 32];
        assign bus_hit = bus_wr_w & hit_gpr_w & (bus_idx_w == 4'(g));
        assign gpr_nxt[g] = dp_hit  ? lane_merge(gpr_r[g], lane_d,
                                                 wr_size_i) :
                            bus_hit ? be_merge(gpr_r[g], avs_writedata_i,
                                               avs_byteenable_i) :
                            gpr_r[g];
    end

    // register array, frame and argument pointers are plain entries
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < GFSW_NREG; i++) gpr_r[i] <= GPR_RST;
        end else begin
            for (int i = 0; i < GFSW_NREG; i++) begin
                gpr_r[i] <= gpr_nxt[i];
            end
        end
    end

    // special registers exposed to the fetch and stack logic
    assign program_counter_reg_o = gpr_r[15];
    assign stack_pointer_reg_o   = gpr_r[14];

    // ************************************************************
    // register and field reads
    // ************************************************************
    logic [127:0] rd_raw_w;
    logic [127:0] rd_mask_w;
    logic [63:0]  pair_w;
    logic [63:0]  pair_sh_w;
    logic [31:0]  fld_mask_w;

    // four consecutive registers, lowest index in the low word
    assign rd_raw_w  = {gpr_r[rd_idx_i + 4'h3], gpr_r[rd_idx_i + 4'h2],
                        gpr_r[rd_idx_i + 4'h1], gpr_r[rd_idx_i]};
    assign rd_mask_w = (rd_size_i == GFSW_SZ_BYTE) ? 128'hff :
                       (rd_size_i == GFSW_SZ_WORD) ? 128'hffff :
                       (rd_size_i == GFSW_SZ_LONG) ? 128'hffff_ffff :
                       (rd_size_i == GFSW_SZ_QUAD) ? {64'h0, {64{1'b1}}} :
                       {128{1'b1}};

    // pair n+1:n as one 64-bit value, start bit limited to 0..31
    assign pair_w     = {gpr_r[fld_idx_i + 4'h1], gpr_r[fld_idx_i]};
    assign pair_sh_w  = pair_w >> fld_pos_i;
    assign fld_mask_w = (fld_len_i >= 6'd32) ? 32'hffff_ffff :
                        ((32'h1 << fld_len_i[4:0]) - 32'h1);

    // registered read data
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_r <= '0;
            fld_r     <= 32'h0000_0000;
        end else begin
            rd_data_r <= rd_raw_w & rd_mask_w;
            fld_r     <= pair_sh_w[31:0] & fld_mask_w;
        end
    end

    assign rd_data_o  = rd_data_r;
    assign fld_data_o = fld_r;

    // ************************************************************
    // status word
    // ************************************************************
    logic [31:0] psw_be_w;
    logic [15:0] psw_bus_w;
    logic [15:0] psw_dp_w;
    logic [15:0] psw_call_w;
    logic        ovf_evt_w;
    logic        t_w;
    logic        iv_w;
    logic        fu_w;
    logic        dv_w;

    assign t_w  = psw_r[PSW_T_BIT];
    assign iv_w = psw_r[PSW_IV_BIT];
    assign fu_w = psw_r[PSW_FU_BIT];
    assign dv_w = psw_r[PSW_DV_BIT];

    // overflow events set V whatever the enables say
    assign ovf_evt_w = insn_end_i & (int_ovf_i | dec_ovf_i);

    // bus write, then datapath load, then call entry, then codes
    assign psw_be_w   = be_merge({16'h0000, psw_r}, avs_writedata_i,
                                 avs_byteenable_i);
    assign psw_bus_w  = (bus_wr_w & hit_psw_w) ?
                        (psw_be_w[15:0] & PSW_WMASK) : psw_r;
    assign psw_dp_w   = psw_wr_i ? (psw_wdata_i & PSW_WMASK) : psw_bus_w;
    always_comb begin
        psw_call_w = psw_dp_w;
        if (call_entry_i) begin
            psw_call_w[PSW_IV_BIT] = call_iv_i;
            psw_call_w[PSW_DV_BIT] = call_dv_i;
            psw_call_w[PSW_FU_BIT] = 1'b0;
        end
    end

    // condition codes from the datapath result
    always_comb begin
        psw_nxt = psw_call_w;
        if (cc_upd_i[0]) psw_nxt[PSW_C_BIT] = cc_val_i[0];
        if (cc_upd_i[1]) psw_nxt[PSW_V_BIT] = cc_val_i[1];
        if (cc_upd_i[2]) psw_nxt[PSW_Z_BIT] = cc_val_i[2];
        if (cc_upd_i[3]) psw_nxt[PSW_N_BIT] = cc_val_i[3];
        if (ovf_evt_w)   psw_nxt[PSW_V_BIT] = 1'b1;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) psw_r <= PSW_RST;
        else       psw_r <= psw_nxt;
    end

    assign processor_status_word_o = psw_r;

    // ************************************************************
    // trace and exception decision at instruction end
    // ************************************************************
    logic tp_cause_w;

    // trace pending as seen at the end of this instruction
    assign tp_cause_w = tp_r | (insn_start_i & t_w);
    assign tp_nxt     = insn_end_i ? 1'b0 :
                        (insn_start_i & t_w) ? 1'b1 : tp_r;

    // enabled and permanent exceptions, one pulse each
    assign exc_nxt[0] = insn_end_i & tp_cause_w;
    assign exc_nxt[1] = insn_end_i & int_ovf_i & iv_w;
    assign exc_nxt[2] = insn_end_i & dec_ovf_i & dv_w;
    assign exc_nxt[3] = insn_end_i & flt_unf_i & fu_w;
    assign exc_nxt[4] = insn_end_i & flt_ovf_i;
    assign exc_nxt[5] = insn_end_i & div_zero_i;
    assign exc_nxt[6] = insn_end_i & flt_div_zero_i;
    assign exc_nxt[7] = 1'b0;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tp_r  <= 1'b0;
            exc_r <= 8'h00;
        end else begin
            tp_r  <= tp_nxt;
            exc_r <= exc_nxt;
        end
    end

    assign trace_pending_o = tp_r;
    assign trace_fault_o   = exc_r[0];
    assign int_ovf_trap_o  = exc_r[1];
    assign dec_ovf_trap_o  = exc_r[2];
    assign flt_unf_fault_o = exc_r[3];
    assign flt_ovf_fault_o = exc_r[4];
    assign div_zero_trap_o = exc_r[5];
    assign flt_div_fault_o = exc_r[6];

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    logic [31:0] wr_old_w;
    logic [31:0] wr_hi_w;
    assign wr_old_w = gpr_r[wr_idx_i];
    assign wr_hi_w  = wr_data_i[63:32];

    a_byte_write_keeps: assert property (
        wr_en_i && wr_size_i == GFSW_SZ_BYTE |=>
        gpr_r[$past(wr_idx_i)][31:8] == $past(wr_old_w[31:8]))
        else $error("byte write disturbed upper bits");
    a_quad_high_half: assert property (
        wr_en_i && wr_size_i == GFSW_SZ_QUAD |=>
        gpr_r[$past(wr_idx_i) + 4'h1] == $past(wr_hi_w))
        else $error("quad high half not in next register");
    a_trace_fault_time: assert property (
        insn_end_i |=> trace_fault_o == $past(tp_cause_w) && !tp_r)
        else $error("trace fault or pending wrong");
    a_int_ovf_gate: assert property (
        insn_end_i && int_ovf_i |=>
        int_ovf_trap_o == $past(iv_w) && psw_r[PSW_V_BIT])
        else $error("integer overflow trap or flag wrong");
    a_underflow_gate: assert property (
        insn_end_i && flt_unf_i |=> flt_unf_fault_o == $past(fu_w))
        else $error("underflow fault gating wrong");
    a_div_zero_always: assert property (
        insn_end_i && div_zero_i |=> div_zero_trap_o)
        else $error("divide by zero trap missing");
    a_flt_ovf_always: assert property (
        insn_end_i && flt_ovf_i |=> flt_ovf_fault_o)
        else $error("floating overflow fault missing");
    a_call_entry_bits: assert property (
        call_entry_i |=> !psw_r[PSW_FU_BIT] && $stable(t_w) &&
        psw_r[PSW_IV_BIT] == $past(call_iv_i))
        else $error("call entry enables wrong");
    a_zero_flag_update: assert property (
        cc_upd_i[2] |=> psw_r[PSW_Z_BIT] == $past(cc_val_i[2]))
        else $error("zero flag not updated");
    a_bus_one_wait: assert property (
        bus_req_w && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus answer later than one wait cycle");

    c_octa_write:  cover property (wr_en_i && wr_size_i == GFSW_SZ_OCTA);
    c_trace_fault: cover property (trace_fault_o);
    c_bus_read:    cover property (avs_read_i && !avs_waitrequest_o);
    c_call_entry:  cover property (call_entry_i && t_w);

endmodule // gfsw_core
